// ==== external_interrupt_latch.sv ====
/*
 * External interrupt latch: catches an active-low request pin, masks it and
 * hands it to the CPU priority logic, with a small register port.
 * Assumes a single core clock, a CPU that pulses vector_fetch when it reads
 * this interrupt's vector, and a break state level from the system unit.
 */
// What this block does
// - Falling pin edge sets the latch
// - Vector fetch clears the latch
// - Writing one to acknowledge clears latch
// - Reset clears the latch
// - Level mode: hold until cleared and pin high
// - Clear and pin release in either order
// - Edge mode: clear acts at once
// - Local mask withholds request from CPU
// - CPU global mask blocks request to CPU, not wake
// - Edge after acknowledge sets latch again
// - Vector sits at fffa and fffb
// - Pin level readable by branch instructions
// - Unmasked request wakes from wait
// - Unmasked request wakes from stop
// - Break protection blocks acknowledge writes
// - Clear during break stays after break
// - Acknowledge bit write-only, reads zero
// - Mask bit read/write, resets zero
// - Mode bit read/write, resets zero
// - Read-only flag shows latched event
`timescale 1ns/1ps
module external_interrupt_latch
    import ext_irq_pkg::*;
(
    input  wire logic        core_clk,       // Core clock, 250 MHz
    input  wire logic        resetn,         // Async reset, active low
    input  wire logic        irq_pin_n,      // External request pin, active low
    input  wire logic        vector_fetch,   // CPU fetching this vector, pulse
    input  wire logic        break_state,    // Break state active
    input  wire logic        cpu_int_mask,   // CPU global interrupt mask
    input  wire logic [3:0]  addr,           // Register address
    input  wire logic [7:0]  wdata,          // Write data
    input  wire logic        wr,             // Write strobe
    input  wire logic        rd,             // Read strobe
    output logic      [7:0]  rdata,          // Read data, cycle after rd
    output logic             irq_request,    // Request to CPU priority logic
    output logic             wake_request,   // Wake from wait or stop
    output logic             pin_level       // Synchronised pin level
);

    // ****************************************
    // State
    // ****************************************
    state_s s_q;
    state_s s_d;

    logic wr_scr;
    logic wr_brk;
    logic ack_clear;
    logic clr_evt;
    logic fall;

    always_comb begin
        s_d       = s_q;
        wr_scr    = wr && (addr == `EXT_INT_STATUS_CONTROL_REG_ADDR);
        wr_brk    = wr && (addr == `BREAK_FLAG_CONTROL_REG_ADDR);
        // Break protection only gates software clears, never fetches
        ack_clear = wr_scr && wdata[`EXT_INT_ACK_BIT_POS]
                    && (!break_state || s_q.break_clear_enable);
        clr_evt   = vector_fetch || ack_clear;
        fall      = s_q.pin_prev && !s_q.pin_sync;

        // Only the second and third stages feed logic
        s_d.pin_meta = irq_pin_n;
        s_d.pin_sync = s_q.pin_meta;
        s_d.pin_prev = s_q.pin_sync;

        // A new edge wins over a simultaneous clear
        if (fall) begin
            s_d.latch    = 1'b1;
            s_d.clr_pend = 1'b0;
        end else if (s_q.mode && !s_q.pin_sync) begin
            // Clear seen while pin low waits for pin release
            s_d.latch    = s_q.latch;
            s_d.clr_pend = s_q.clr_pend || (clr_evt && s_q.latch);
        end else if (clr_evt || s_q.clr_pend) begin
            s_d.latch    = 1'b0;
            s_d.clr_pend = 1'b0;
        end

        if (wr_scr) begin
            s_d.mask = wdata[`EXT_INT_MASK_BIT_POS];
            s_d.mode = wdata[`TRIGGER_SENSE_SELECT_BIT];
        end
        if (wr_brk) begin
            s_d.break_clear_enable = wdata[`BREAK_CLEAR_ENABLE_POS];
        end

        s_d.rdata = `EXT_INT_DATA_ZERO;
        if (rd && addr == `EXT_INT_STATUS_CONTROL_REG_ADDR) begin
            s_d.rdata[`EXT_INT_EVENT_FLAG_POS]   = s_q.latch;
            s_d.rdata[`EXT_INT_MASK_BIT_POS]     = s_q.mask;
            s_d.rdata[`TRIGGER_SENSE_SELECT_BIT] = s_q.mode;
        end else if (rd && addr == `BREAK_FLAG_CONTROL_REG_ADDR) begin
            s_d.rdata[`BREAK_CLEAR_ENABLE_POS]   = s_q.break_clear_enable;
        end

        // CPU vectors to fffa/fffb on this request
        s_d.irq_req   = s_q.latch && !s_q.mask && !cpu_int_mask;
        // Wake ignores the global mask, as the CPU does in wait and stop
        s_d.wake      = s_q.latch && !s_q.mask;
        s_d.pin_level = s_q.pin_sync;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q          <= '0;
            s_q.pin_meta <= 1'b1;
            s_q.pin_sync <= 1'b1;
            s_q.pin_prev <= 1'b1;
            s_q.pin_level <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata        = s_q.rdata;
    assign irq_request  = s_q.irq_req;
    assign wake_request = s_q.wake;
    assign pin_level    = s_q.pin_level;

    // ****************************************
    // Assertions
    // ****************************************
    sequence fall_seen;
        s_q.pin_prev && !s_q.pin_sync;
    endsequence

    a_edge_sets_latch: assert property (@(posedge core_clk) disable iff (!resetn)
        fall_seen |=> s_q.latch) else $error("edge did not set latch");
    a_fetch_clears_edge: assert property (@(posedge core_clk) disable iff (!resetn)
        vector_fetch && !s_q.mode && !(s_q.pin_prev && !s_q.pin_sync) |=> !s_q.latch)
        else $error("fetch did not clear latch");
    a_level_holds_latch: assert property (@(posedge core_clk) disable iff (!resetn)
        s_q.latch && s_q.mode && !s_q.pin_sync |=> s_q.latch)
        else $error("latch dropped while pin low");
    a_break_protects: assert property (@(posedge core_clk) disable iff (!resetn)
        s_q.latch && break_state && !s_q.break_clear_enable && !vector_fetch && !s_q.clr_pend
        |=> s_q.latch)
        else $error("ack cleared latch in break");
    a_mask_withholds: assert property (@(posedge core_clk) disable iff (!resetn)
        s_q.mask |=> !irq_request) else $error("masked request forwarded");
    a_request_forwarded: assert property (@(posedge core_clk) disable iff (!resetn)
        s_q.latch && !s_q.mask && !cpu_int_mask |=> irq_request)
        else $error("request not forwarded");
    a_ack_reads_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        rd |=> !rdata[`EXT_INT_ACK_BIT_POS]) else $error("ack bit read nonzero");
    a_flag_mirrors: assert property (@(posedge core_clk) disable iff (!resetn)
        rd && addr == `EXT_INT_STATUS_CONTROL_REG_ADDR
        |=> rdata[`EXT_INT_EVENT_FLAG_POS] == $past(s_q.latch))
        else $error("flag does not match latch");
    a_wake_follows: assert property (@(posedge core_clk) disable iff (!resetn)
        s_q.latch && !s_q.mask |=> wake_request) else $error("no wake");
    a_pin_level: assert property (@(posedge core_clk) disable iff (!resetn)
        1'b1 |-> ##3 pin_level == $past(irq_pin_n, 3)) else $error("pin level wrong");

    // ****************************************
    // Step-by-step checks
    // ****************************************
    default clocking cb_core @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    logic ack_try;
    assign ack_try = wr && (addr == `EXT_INT_STATUS_CONTROL_REG_ADDR)
                     && wdata[`EXT_INT_ACK_BIT_POS];

    sequence sync_fall;
        s_q.pin_sync && !s_q.pin_meta;
    endsequence

    sequence scr_write;
        wr && addr == `EXT_INT_STATUS_CONTROL_REG_ADDR;
    endsequence

    sequence scr_read;
        rd && addr == `EXT_INT_STATUS_CONTROL_REG_ADDR;
    endsequence

    sequence brk_write;
        wr && addr == `BREAK_FLAG_CONTROL_REG_ADDR;
    endsequence

    sequence brk_read;
        rd && addr == `BREAK_FLAG_CONTROL_REG_ADDR;
    endsequence

    a_meta_samples_pin: assert property (
        1'b1
        |=> s_q.pin_meta == $past(irq_pin_n))
        else $error("pin not sampled");

    a_sync_second_stage: assert property (
        1'b1
        |=> s_q.pin_sync == $past(s_q.pin_meta))
        else $error("second stage wrong");

    a_prev_stage: assert property (
        1'b1
        |=> s_q.pin_prev == $past(s_q.pin_sync))
        else $error("edge stage wrong");

    a_level_output: assert property (
        1'b1
        |=> pin_level == $past(s_q.pin_sync))
        else $error("pin level output wrong");

    a_fall_walk: assert property (
        sync_fall
        |=> fall ##1 s_q.latch)
        else $error("fall walk broken");

    a_request_walk: assert property (
        sync_fall ##2 (!s_q.mask && !cpu_int_mask)
        |=> irq_request)
        else $error("request walk broken");

    a_wake_walk: assert property (
        sync_fall ##2 !s_q.mask
        |=> wake_request)
        else $error("wake walk broken");

    a_only_edges_set: assert property (
        !s_q.latch && !fall
        |=> !s_q.latch)
        else $error("latch set without edge");

    a_ack_clears_edge: assert property (
        ack_try && !s_q.mode && !fall && (!break_state || s_q.break_clear_enable)
        |=> !s_q.latch)
        else $error("ack did not clear");

    a_ack_clears_high: assert property (
        ack_try && s_q.mode && s_q.pin_sync && !fall && (!break_state || s_q.break_clear_enable)
        |=> !s_q.latch)
        else $error("ack did not clear in level mode");

    a_fetch_clears_high: assert property (
        vector_fetch && s_q.mode && s_q.pin_sync && !fall
        |=> !s_q.latch)
        else $error("fetch did not clear in level mode");

    a_fetch_in_break: assert property (
        vector_fetch && break_state && !s_q.mode && !fall
        |=> !s_q.latch)
        else $error("fetch blocked by break");

    a_clear_waits_pin: assert property (
        s_q.latch && s_q.mode && !s_q.pin_sync && vector_fetch && !fall
        |=> s_q.clr_pend)
        else $error("clear while low not kept");

    a_pending_clears: assert property (
        s_q.clr_pend && s_q.pin_sync && !fall
        |=> !s_q.latch)
        else $error("pending clear not applied");

    a_pending_holds: assert property (
        s_q.clr_pend && s_q.mode && !s_q.pin_sync
        |=> s_q.latch)
        else $error("latch dropped while low");

    a_edge_cancels_pend: assert property (
        fall
        |=> !s_q.clr_pend && s_q.latch)
        else $error("edge did not renew request");

    a_edge_beats_ack: assert property (
        fall && ack_try
        |=> s_q.latch)
        else $error("ack beat new edge");

    a_break_allows: assert property (
        ack_try && break_state && s_q.break_clear_enable && !s_q.mode && !fall
        |=> !s_q.latch)
        else $error("ack blocked with clear enable");

    a_break_blocks_ack: assert property (
        ack_try && break_state && !s_q.break_clear_enable && s_q.latch && !vector_fetch
        && !s_q.clr_pend
        |=> s_q.latch)
        else $error("ack acted during break");

    a_pend_needs_latch: assert property (
        s_q.clr_pend
        |-> s_q.latch)
        else $error("pending clear without latch");

    a_mask_read_back: assert property (
        scr_write ##1 scr_read
        |=> rdata[`EXT_INT_MASK_BIT_POS] == $past(wdata[`EXT_INT_MASK_BIT_POS], 2))
        else $error("mask read back wrong");

    a_mode_read_back: assert property (
        scr_write ##1 scr_read
        |=> rdata[`TRIGGER_SENSE_SELECT_BIT] == $past(wdata[`TRIGGER_SENSE_SELECT_BIT], 2))
        else $error("mode read back wrong");

    a_break_clear_enable_read_back: assert property (
        brk_write ##1 brk_read
        |=> rdata[`BREAK_CLEAR_ENABLE_POS] == $past(wdata[`BREAK_CLEAR_ENABLE_POS], 2))
        else $error("clear enable read back wrong");

    a_ack_never_read: assert property (
        scr_read
        |=> !rdata[`EXT_INT_ACK_BIT_POS] && !rdata[`BREAK_CLEAR_ENABLE_POS])
        else $error("write-only bit read");

    a_idle_reads_zero: assert property (
        !rd
        |=> rdata == `EXT_INT_DATA_ZERO)
        else $error("read data without read");

    a_unmapped_zero: assert property (
        rd && addr != `EXT_INT_STATUS_CONTROL_REG_ADDR
        && addr != `BREAK_FLAG_CONTROL_REG_ADDR
        |=> rdata == `EXT_INT_DATA_ZERO)
        else $error("unmapped read nonzero");

    a_brk_other_bits: assert property (
        brk_read
        |=> !rdata[`EXT_INT_ACK_BIT_POS] && !rdata[`EXT_INT_EVENT_FLAG_POS]
        && !rdata[`EXT_INT_MASK_BIT_POS] && !rdata[`TRIGGER_SENSE_SELECT_BIT])
        else $error("break register stray bits");

    a_global_blocks: assert property (
        cpu_int_mask
        |=> !irq_request)
        else $error("global mask ignored");

    a_idle_no_request: assert property (
        !s_q.latch
        |=> !irq_request && !wake_request)
        else $error("request without latch");

    a_mask_blocks_wake: assert property (
        s_q.mask
        |=> !wake_request)
        else $error("masked wake");

    a_wake_ignores_global: assert property (
        s_q.latch && !s_q.mask && cpu_int_mask
        |=> wake_request && !irq_request)
        else $error("wake and request split wrong");

    a_mask_write_lands: assert property (
        scr_write
        |=> s_q.mask == $past(wdata[`EXT_INT_MASK_BIT_POS])
        && s_q.mode == $past(wdata[`TRIGGER_SENSE_SELECT_BIT]))
        else $error("control write lost");

    a_flag_clear_read: assert property (
        scr_read && !s_q.latch
        |=> !rdata[`EXT_INT_EVENT_FLAG_POS])
        else $error("flag set without latch");

endmodule

// ==== ext_irq_regs.svh ====
/*
 * Register map, field positions and constants of the external interrupt latch.
 * Assumes inclusion by bare name from the package, which the design module imports.
 */
`ifndef EXT_IRQ_REGS_SVH
`define EXT_IRQ_REGS_SVH

// ****************************************
// Register map
// ****************************************
`define EXT_INT_STATUS_CONTROL_REG_ADDR 4'h0
`define BREAK_FLAG_CONTROL_REG_ADDR     4'h1
`define EXT_INT_ADDR_W                  4

// ****************************************
// Field positions of the status/control and break flag control registers
// ****************************************
`define TRIGGER_SENSE_SELECT_BIT 0
`define EXT_INT_MASK_BIT_POS     1
`define EXT_INT_ACK_BIT_POS      2
`define EXT_INT_EVENT_FLAG_POS   3
`define BREAK_CLEAR_ENABLE_POS   7

// ****************************************
// Reset values and vector
// ****************************************
`define EXT_INT_DATA_ZERO        8'h00
`define EXT_INT_VECTOR_HI_ADDR   16'hfffa
`define EXT_INT_VECTOR_LO_ADDR   16'hfffb

`endif

// ==== ext_irq_pkg.sv ====
/*
 * Types shared by the external interrupt latch.
 * Assumes ext_irq_regs.svh is on the include path.
 */
package ext_irq_pkg;
    `include "ext_irq_regs.svh"

    typedef logic [7:0]                  byte_t;
    typedef logic [`EXT_INT_ADDR_W-1:0]  addr_t;

    typedef struct packed {
        logic  pin_meta;
        logic  pin_sync;
        logic  pin_prev;
        logic  latch;
        logic  clr_pend;
        logic  mask;
        logic  mode;
        logic  break_clear_enable;
        byte_t rdata;
        logic  irq_req;
        logic  wake;
        logic  pin_level;
    } state_s;
endpackage

// ==== irq_line_driver.sv ====
/* Stand-in for the external source on the active-low request line.
   Assumes the bench asks for a low level through drive_low. */
`timescale 1ns/1ps
module irq_line_driver (
    input  wire logic drive_low, // Hold the line low
    output logic      irq_pin_n  // Active-low request line
);
    // Released line is driven high, standing in for its pull-up
    assign irq_pin_n = drive_low ? 1'b0 : 1'b1;
endmodule

// ==== external_interrupt_latch_test.sv ====
/* Self-checking bench for the external interrupt latch.
   Assumes the package and the line driver are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module external_interrupt_latch_test;
    import ext_irq_pkg::*;
    logic       core_clk = 0, resetn = 0, low = 0, fetch = 0, brk = 0, cim = 0;
    logic       wr = 0, rd = 0, irq_pin_n, irq_request, wake_request, pin_level;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, v;
    int         bad_count = 0, n_tests = 0, lat = 0, msk = 0, mod = 0, bcf = 0, pend = 0;
    always #2 core_clk = ~core_clk;
    irq_line_driver u_irq_line_driver (.drive_low(low), .irq_pin_n(irq_pin_n));
    external_interrupt_latch u_external_interrupt_latch (.core_clk(core_clk),
        .resetn(resetn), .irq_pin_n(irq_pin_n), .vector_fetch(fetch), .break_state(brk),
        .cpu_int_mask(cim), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq_request(irq_request), .wake_request(wake_request), .pin_level(pin_level));
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic set_ctl(input int ms, input int md);
        // Random upper nibble exercises the unused bits
        wr_reg(4'h0, {4'($urandom), 2'b00, 1'(ms), 1'(md)});
        msk = ms;
        mod = md;
    endtask
    task automatic pin(input int l);
        @(posedge core_clk);
        low <= 1'(l);
        if (l != 0) begin
            lat = 1;
            pend = 0;
        end else if (pend != 0) begin
            lat = 0;
        end
    endtask
    task automatic pulse();
        pin(1);
        repeat ($urandom_range(3, 7)) @(posedge core_clk);
        pin(0);
    endtask
    task automatic clr(input int by_fetch);
        if (by_fetch != 0) begin
            @(posedge core_clk);
            fetch <= 1'b1;
            @(posedge core_clk);
            fetch <= 1'b0;
        end else begin
            wr_reg(4'h0, {4'($urandom), 2'b01, 1'(msk), 1'(mod)});
        end
        if (by_fetch != 0 || brk == 0 || bcf != 0) begin
            if (mod != 0 && low) pend = 1;
            else lat = 0;
        end
    endtask
    task automatic chk_all();
        repeat (8) @(posedge core_clk);
        #1;
        `CHK("irq", 1'(lat != 0 && msk == 0 && !cim), irq_request)
        `CHK("wake", 1'(lat != 0 && msk == 0), wake_request)
        `CHK("pin", !low, pin_level)
        rd_reg(4'h0);
        `CHK("ctl", {4'h0, 1'(lat), 1'b0, 1'(msk), 1'(mod)}, v)
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        complete_run();
    end
    initial begin
        void'($urandom(73367));
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        chk_all();
        rd_reg(4'h1);
        `CHK("break_clear_enable", 8'h00, v)
        rd_reg(4'h9);
        `CHK("unmapped", 8'h00, v)
        for (int m = 0; m < 2; m++) begin
            set_ctl(0, m);
            pulse();
            chk_all();
            clr(0);
            chk_all();
            pulse();
            clr(1);
            chk_all();
            pin(1);
            chk_all();
            clr(0);
            chk_all();
            pin(0);
            chk_all();
        end
        set_ctl(1, 0);
        pulse();
        chk_all();
        set_ctl(0, 0);
        chk_all();
        cim <= 1'b1;
        chk_all();
        cim <= 1'b0;
        brk <= 1'b1;
        clr(0);
        chk_all();
        wr_reg(4'h1, 8'h80);
        bcf = 1;
        rd_reg(4'h1);
        `CHK("break_clear_enable", 8'h80, v)
        clr(0);
        brk <= 1'b0;
        chk_all();
        pulse();
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        {lat, msk, mod, bcf} = '0;
        chk_all();
        complete_run();
    end
endmodule
